/* File: amb_master.sv */
// Master end of the asynchronous multiplexed expansion bus basic cycle
`timescale 1ns/10ps
// Function
// - Each cycle moves a 32-bit address then 32 data bits on shared lines.
// - Master drives address and space code together, then asserts full-cycle strobe.
// - Slave latches address at strobe fall; master releases address soon after.
// - Controller raises bus error on multiple claims or local-bus address claims.
// - Master opens data phase with data enable; same strobes for both directions.
// - Reads assert at least one lane strobe; cacheable slaves return 32 bits.
// - Master ends read by dropping strobe; slave drops claim and data.
// - On writes master drives data, then lane strobes mark valid bytes.
// - Write data held until acknowledge; then master may end and release.
// - Master samples acknowledge only after lane strobes; slave may ack early.
// - Handshakes follow strobe edges, never a bus reference clock; setup delays and timeouts count clk_in cycles.
module amb_master
  import amb_pkg::*;
#(
  parameter int unsigned CLAIM_WAIT = CLAIM_WAIT_CYC,
  parameter int unsigned ACK_WAIT = ACK_WAIT_CYC
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic req_in,
  input wire logic req_write_in,
  input wire logic [amb_pkg::ADDR_W-1:0] req_addr_in,
  input wire logic [amb_pkg::SPACE_W-1:0] req_space_in,
  input wire logic [amb_pkg::LANES-1:0] req_lanes_in,
  input wire logic [amb_pkg::DATA_W-1:0] req_wdata_in,
  output logic req_ready_out,
  output logic done_out,
  output logic error_out,
  output logic [amb_pkg::DATA_W-1:0] rdata_out,
  input wire logic [amb_pkg::DATA_W-1:0] ad_in,
  output logic [amb_pkg::DATA_W-1:0] ad_out,
  output logic ad_oe_n_out,
  output logic [amb_pkg::LOW_MSB:amb_pkg::LOW_LSB] low_direct_address_out,
  output logic [amb_pkg::SPACE_W-1:0] memory_space_code_out,
  output logic read_out,
  output logic full_cycle_strobe_n_out,
  output logic data_phase_enable_out,
  output logic [amb_pkg::LANES-1:0] byte_lane_strobes_n_out,
  input wire logic slot_claim_n_in,
  input wire logic transfer_acknowledge_n_in,
  input wire logic bus_error_n_in
);
  amb_state_t state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [2:0] sync_w;
  logic claim_w, ack_w, bus_error_w;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] wdata_r;
  logic [LANES-1:0] lanes_r;
  logic write_r;
  logic cnt_zero_w, start_w, claim_to_w, ack_to_w;
  logic ack_ok_w, go_strb_w, go_claim_w, go_data_w, go_lane_w, go_end_w;
  logic ack_end_w, claim_end_w;

  // True on the edge that moves the machine from another state into s
  function automatic logic enters(
    input amb_state_t cur,
    input amb_state_t nxt,
    input amb_state_t s
  );
    return (nxt == s) && (cur != s);
  endfunction : enters

  amb_sync #(.WIDTH(3)) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in({~slot_claim_n_in, ~transfer_acknowledge_n_in, ~bus_error_n_in}),
    .sync_out(sync_w)
  );

  assign claim_w = sync_w[2];
  assign ack_w = sync_w[1];
  assign bus_error_w = sync_w[0];
  assign cnt_zero_w = (cnt_r == '0);
  assign start_w = req_in && (state_r == AMB_IDLE);
  assign claim_to_w = (cnt_r >= CNT_W'(CLAIM_WAIT));
  assign ack_to_w = (cnt_r >= CNT_W'(ACK_WAIT));
  // First ack cycle still shows the pin from before the lanes fell, so skip it
  assign ack_ok_w = ack_w && !cnt_zero_w;
  assign go_strb_w = enters(state_r, state_nxt, AMB_STRB);
  assign go_claim_w = enters(state_r, state_nxt, AMB_CLAIM);
  assign go_data_w = enters(state_r, state_nxt, AMB_DATA);
  assign go_lane_w = enters(state_r, state_nxt, AMB_LANE);
  assign go_end_w = enters(state_r, state_nxt, AMB_END);
  assign ack_end_w = (state_r == AMB_ACK) && go_end_w;
  assign claim_end_w = (state_r == AMB_CLAIM) && go_end_w;

  // Next state; all steps but STRB and LANE wait on the request, a slave strobe, a setup count or a timeout
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      AMB_IDLE: if (req_in) state_nxt = AMB_ADDR;
      AMB_ADDR: if (cnt_zero_w) state_nxt = AMB_STRB;
      AMB_STRB: state_nxt = AMB_CLAIM;
      AMB_CLAIM: begin
        if (bus_error_w || claim_to_w) state_nxt = AMB_END;
        else if (claim_w) state_nxt = AMB_DATA;
      end
      AMB_DATA: if (cnt_zero_w) state_nxt = AMB_LANE;
      AMB_LANE: state_nxt = AMB_ACK;
      AMB_ACK: begin
        if (bus_error_w || ack_to_w) state_nxt = AMB_END;
        else if (ack_ok_w) state_nxt = AMB_END;
      end
      // Wait for slave to drop claim so the next cycle starts clean
      AMB_END: if (!claim_w && !ack_w) state_nxt = AMB_IDLE;
      default: state_nxt = AMB_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_r <= AMB_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_r <= '0;
    end else if (state_nxt != state_r) begin
      if (state_nxt == AMB_ADDR) cnt_r <= CNT_W'(ADDR_SETUP_CYC - 1);
      else if (state_nxt == AMB_DATA) cnt_r <= CNT_W'(DATA_SETUP_CYC - 1);
      else cnt_r <= '0;
    end else if (state_r == AMB_ADDR || state_r == AMB_DATA) begin
      if (!cnt_zero_w) cnt_r <= cnt_r - 1'b1;
    end else if (!claim_to_w || !ack_to_w) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      addr_r <= '0;
      wdata_r <= '0;
      lanes_r <= LANES_NONE;
      write_r <= 1'b0;
    end else if (start_w) begin
      addr_r <= req_addr_in;
      wdata_r <= req_wdata_in;
      lanes_r <= (req_lanes_in == LANES_NONE) ? LANES_ALL : req_lanes_in;
      write_r <= req_write_in;
    end
  end

  // Address and write data share the AD lines, so one block owns their drive
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ad_out <= '0;
      ad_oe_n_out <= 1'b1;
    end else if (start_w) begin
      ad_out <= req_addr_in;
      ad_oe_n_out <= 1'b0;
    end else if (go_claim_w || go_end_w) begin
      ad_oe_n_out <= 1'b1;
    end else if (go_data_w && write_r) begin
      ad_out <= wdata_r;
      ad_oe_n_out <= 1'b0;
    end
  end

  // Address phase pins
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      low_direct_address_out <= '0;
      memory_space_code_out <= '0;
      read_out <= 1'b1;
      full_cycle_strobe_n_out <= 1'b1;
    end else begin
      if (start_w) begin
        low_direct_address_out <= req_addr_in[LOW_MSB:LOW_LSB];
        memory_space_code_out <= req_space_in;
        read_out <= !req_write_in;
      end
      if (go_strb_w) full_cycle_strobe_n_out <= 1'b0;
      if (go_end_w) full_cycle_strobe_n_out <= 1'b1;
    end
  end

  // Data phase pins
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      data_phase_enable_out <= 1'b0;
      byte_lane_strobes_n_out <= LANES_ALL;
    end else begin
      if (go_data_w) data_phase_enable_out <= 1'b1;
      if (go_lane_w) byte_lane_strobes_n_out <= ~lanes_r;
      if (go_end_w) begin
        data_phase_enable_out <= 1'b0;
        byte_lane_strobes_n_out <= LANES_ALL;
      end
    end
  end

  // User side
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      req_ready_out <= 1'b0;
      done_out <= 1'b0;
      error_out <= 1'b0;
      rdata_out <= '0;
    end else begin
      req_ready_out <= (state_nxt == AMB_IDLE) && !start_w;
      done_out <= 1'b0;
      error_out <= 1'b0;
      if (ack_end_w) begin
        done_out <= 1'b1;
        error_out <= bus_error_w || !ack_ok_w;
        // Data already passed the sync delay of the ack, so it has settled
        if (!write_r) rdata_out <= ad_in;
      end else if (claim_end_w) begin
        done_out <= 1'b1;
        error_out <= 1'b1;
      end
    end
  end
endmodule : amb_master

/* File: amb_master_properties.sv */
// Port assertions for the bus master
`timescale 1ns/10ps
module amb_master_chk (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic done_out,
  input wire logic ad_oe_n_out,
  input wire logic [7:2] low_direct_address_out,
  input wire logic read_out,
  input wire logic full_cycle_strobe_n_out,
  input wire logic data_phase_enable_out,
  input wire logic [3:0] byte_lane_strobes_n_out,
  input wire logic slot_claim_n_in,
  input wire logic transfer_acknowledge_n_in
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  // Two synchroniser edges, then the cycle must end
  sequence s_acked;
    (!transfer_acknowledge_n_in && ~&byte_lane_strobes_n_out)[*3];
  endsequence
  a_addr_setup: assert property ($fell(full_cycle_strobe_n_out) |->
    $past(!ad_oe_n_out)) else $error("no address setup");
  a_addr_release: assert property ($fell(full_cycle_strobe_n_out) |=> ad_oe_n_out)
    else $error("address held");
  a_low_held: assert property (!full_cycle_strobe_n_out && $past(!full_cycle_strobe_n_out)
    |-> $stable(low_direct_address_out) && $stable(read_out)) else $error("low address moved");
  a_enable_claim: assert property ($rose(data_phase_enable_out) |->
    $past(!slot_claim_n_in, 3)) else $error("unclaimed data phase");
  a_lane_setup: assert property ($rose(~&byte_lane_strobes_n_out) |->
    $past(data_phase_enable_out) && (read_out || !ad_oe_n_out)) else $error("early lanes");
  a_read_float: assert property (data_phase_enable_out && read_out |-> ad_oe_n_out)
    else $error("read data driven");
  a_ack_ends: assert property (s_acked |=> full_cycle_strobe_n_out && done_out)
    else $error("ack ignored");
  a_strobe_end: assert property ($rose(full_cycle_strobe_n_out) |-> done_out && ad_oe_n_out
    && !data_phase_enable_out && &byte_lane_strobes_n_out) else $error("bad cycle end");
endmodule : amb_master_chk
bind amb_master amb_master_chk u_amb_master_chk (.*);

/* File: amb_pkg.sv */
// Package for the asynchronous multiplexed bus master
package amb_pkg;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned LANES = 4;
  localparam int unsigned SPACE_W = 3;
  localparam int unsigned LOW_MSB = 7;
  localparam int unsigned LOW_LSB = 2;
  localparam int unsigned CLK_MHZ = 10;
  // Time from address drive to strobe, and from data enable to lane strobes
  localparam int unsigned ADDR_SETUP_NS = 100;
  localparam int unsigned ADDR_SETUP_CYC = (ADDR_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned DATA_SETUP_NS = 100;
  localparam int unsigned DATA_SETUP_CYC = (DATA_SETUP_NS * CLK_MHZ + 999) / 1000;
  // Claim timeout: no claim within this time ends the cycle with an error
  localparam int unsigned CLAIM_WAIT_NS = 2000;
  localparam int unsigned CLAIM_WAIT_CYC = (CLAIM_WAIT_NS * CLK_MHZ) / 1000;
  localparam int unsigned ACK_WAIT_NS = 100000;
  localparam int unsigned ACK_WAIT_CYC = (ACK_WAIT_NS * CLK_MHZ) / 1000;
  localparam int unsigned CNT_W = 16;
  localparam logic [LANES-1:0] LANES_ALL = 4'hf;
  localparam logic [LANES-1:0] LANES_NONE = 4'h0;
  typedef enum logic [7:0] {
    AMB_IDLE = 8'h01,
    AMB_ADDR = 8'h02,
    AMB_STRB = 8'h04,
    AMB_CLAIM = 8'h08,
    AMB_DATA = 8'h10,
    AMB_LANE = 8'h20,
    AMB_ACK = 8'h40,
    AMB_END = 8'h80
  } amb_state_t;
endpackage : amb_pkg

/* File: amb_slave_model.sv */
// Behavioural slave card answering the bus master
`timescale 1ns/10ps
module amb_slave_model #(parameter logic [7:0] BASE = 8'h40) (
  input wire logic slow,
  input wire logic full_cycle_strobe_n_out,
  input wire logic ad_oe_n_out,
  input wire logic read_out,
  input wire logic [31:0] ad_out,
  input wire logic [7:2] low_direct_address_out,
  input wire logic [2:0] memory_space_code_out,
  input wire logic [3:0] byte_lane_strobes_n_out,
  output logic [31:0] ad_in,
  output logic slot_claim_n_in = 1'b1,
  output logic transfer_acknowledge_n_in = 1'b1
);
  logic [31:0] mem [4];
  initial for (int i = 0; i < 4; i++) mem[i] = 32'h0;
  logic drv = 1'b0;
  wire logic [1:0] word = low_direct_address_out[3:2];
  // Top byte decode only; space code 7 is never claimed
  always @(negedge full_cycle_strobe_n_out)
    if (ad_out[31:24] == BASE && memory_space_code_out != 3'h7)
      #20 slot_claim_n_in = 1'b0;
  always @(negedge (&byte_lane_strobes_n_out)) begin
    for (int i = 0; i < 4; i++)
      if (!read_out && !byte_lane_strobes_n_out[i]) mem[word][8*i+:8] = ad_out[8*i+:8];
    #(slow ? 800 : 30) drv = read_out & ~slot_claim_n_in;
    #10 transfer_acknowledge_n_in = slot_claim_n_in;
  end
  always @(posedge full_cycle_strobe_n_out)
    {slot_claim_n_in, transfer_acknowledge_n_in, drv} = 3'b110;
  // Released lines show the inverse of the last value, never a held copy
  assign ad_in = !ad_oe_n_out ? ad_out : drv ? mem[word] : ~ad_out;
endmodule : amb_slave_model

/* File: amb_sync.sv */
// Two-flop synchroniser for a group of bus inputs
`timescale 1ns/10ps
module amb_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_r <= '0;
      sync_out <= '0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule : amb_sync

/* File: tb.sv */
// Self-checking bench for the bus master
`timescale 1ns/10ps
module tb;
  logic clk_in = 1'b0, rst_in = 1'b1, req_in = 1'b0, bus_error_n_in = 1'b1, slow = 1'b0;
  logic req_write_in, req_ready_out, done_out, error_out, ad_oe_n_out, read_out;
  logic full_cycle_strobe_n_out, data_phase_enable_out, slot_claim_n_in, transfer_acknowledge_n_in;
  logic [31:0] req_addr_in, req_wdata_in, rdata_out, ad_in, ad_out, got, err;
  logic [2:0] req_space_in, memory_space_code_out;
  logic [3:0] req_lanes_in, byte_lane_strobes_n_out;
  logic [7:2] low_direct_address_out;
  int fail_count = 0, checks_done = 0, cyc = 0;
  always #50 clk_in = ~clk_in;
  amb_master #(.CLAIM_WAIT(8), .ACK_WAIT(16)) u_amb_master (.*);
  amb_slave_model u_amb_slave_model (.*);
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      end_sim();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic run(input logic [71:0] r);
    while (req_ready_out !== 1'b1) begin
      @(posedge clk_in);
      #1;
    end
    {req_write_in, req_addr_in, req_space_in, req_lanes_in, req_wdata_in, req_in} = {r, 1'b1};
    @(posedge clk_in);
    #1 req_in = 1'b0;
    // Look one step after the edge, while the one-cycle done pulse stands
    do begin
      @(posedge clk_in);
      #1;
    end while (done_out !== 1'b1);
    err = 32'(error_out);
    got = rdata_out;
  endtask : run
  task automatic t_lanes;
    run({1'b1, 32'h40000008, 3'h1, 4'hf, 32'h11223344});
    check(err, 32'h0);
    slow = 1'b1;
    run({1'b1, 32'h40000008, 3'h1, 4'h5, 32'haabbccdd});
    check(err, 32'h0);
    run({1'b0, 32'h40000008, 3'h1, 4'h1, 32'h0});
    slow = 1'b0;
    check(err, 32'h0);
    check(got, 32'h11bb33dd);
    $display("lanes test done");
  endtask : t_lanes
  task automatic t_refuse;
    for (int s = 0; s < 8; s++) begin
      run({1'b0, 32'h40000000, s[2:0], 4'hf, 32'h0});
      check(err, 32'(s == 7));
    end
    run({1'b0, 32'h50000000, 3'h1, 4'hf, 32'h0});
    check(err, 32'h1);
    bus_error_n_in = 1'b0;
    run({1'b0, 32'h40000000, 3'h1, 4'hf, 32'h0});
    bus_error_n_in = 1'b1;
    check(err, 32'h1);
    $display("refusal test done");
  endtask : t_refuse
  initial begin
    {req_write_in, req_addr_in, req_space_in, req_lanes_in, req_wdata_in} = 72'h0;
    repeat (3) @(posedge clk_in);
    #1 rst_in = 1'b0;
    t_lanes();
    t_refuse();
    end_sim();
  end
endmodule : tb
